// [design/acr_regs.sv]
/*
 * ADC and PLL control register bank: six byte registers written and
 * read over the control port, the decoded controls that steer the record
 * path and clock generators, and the peak level read-back.
 * Assumes the serial port delivers a one-cycle write or read strobe with
 * a 7-bit address, all synchronous to i_clock.
 */
`timescale 1ns/100ps
`default_nettype none
module acr_regs
    import acr_pkg::*;
#(
    parameter int SAMPLE_WIDTH = 24
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_nrst,
    // Register port.
    input wire logic [6:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    // Peak detector levels from the record path.
    input wire logic [5:0] i_peak_left,
    input wire logic [5:0] i_peak_right,
    // Record samples in and scaled out.
    input wire logic signed [SAMPLE_WIDTH-1:0] i_sample_left,
    input wire logic signed [SAMPLE_WIDTH-1:0] i_sample_right,
    input wire logic i_sample_valid,
    output logic signed [SAMPLE_WIDTH-1:0] o_sample_left,
    output logic signed [SAMPLE_WIDTH-1:0] o_sample_right,
    output logic o_sample_valid,
    // ADC controls.
    output logic [2:0] o_modulator_divide,
    output logic [9:0] o_modulator_ratio,
    output logic o_high_pass_enable,
    output logic o_converter_sleep,
    output logic o_analog_section_sleep,
    output logic o_left_gain_amp_sleep,
    output logic o_right_gain_amp_sleep,
    output logic o_reference_buffer_sleep,
    output logic [2:0] o_adc_master_divide,
    // PLL and clock controls.
    output acr_pkg::acr_src_e o_third_clock_source,
    output logic [9:0] o_third_clock_ratio,
    output logic [2:0] o_master_out_divide,
    output logic [2:0] o_xtal_divide,
    output logic o_second_pll_sleep,
    output logic o_first_pll_sleep,
    output logic o_oscillator_sleep,
    output logic [11:0] o_first_pll_rate,
    output logic [9:0] o_first_pll_ratio,
    output logic o_first_pll_reserved,
    output logic [11:0] o_second_pll_rate,
    output logic [9:0] o_second_pll_ratio,
    output logic o_second_pll_reserved
);
    import acr_pkg::*;

    logic [7:0] adc_control_one;
    logic [7:0] adc_control_two;
    logic [7:0] adc_left_volume;
    logic [7:0] adc_right_volume;
    logic [7:0] pll_control_one;
    logic [7:0] pll_control_two;
    logic [5:0] adc_peak_left;
    logic [5:0] adc_peak_right;

    // Write decode by address.
    wire logic wr_ctrl1 = i_write && (i_addr == ACR_ADDR_ADC_CTRL1);
    wire logic wr_ctrl2 = i_write && (i_addr == ACR_ADDR_ADC_CTRL2);
    wire logic wr_vol_l = i_write && (i_addr == ACR_ADDR_VOL_LEFT);
    wire logic wr_vol_r = i_write && (i_addr == ACR_ADDR_VOL_RIGHT);
    wire logic wr_pll1 = i_write && (i_addr == ACR_ADDR_PLL_CTRL1);
    wire logic wr_pll2 = i_write && (i_addr == ACR_ADDR_PLL_CTRL2);

    // Read mux; peak bits above the six-bit field and unmapped addresses read zero.
    logic [7:0] next_rdata;
    always_comb begin
        if (i_addr == ACR_ADDR_ADC_CTRL1) begin
            next_rdata = adc_control_one;
        end else if (i_addr == ACR_ADDR_ADC_CTRL2) begin
            next_rdata = adc_control_two;
        end else if (i_addr == ACR_ADDR_VOL_LEFT) begin
            next_rdata = adc_left_volume;
        end else if (i_addr == ACR_ADDR_VOL_RIGHT) begin
            next_rdata = adc_right_volume;
        end else if (i_addr == ACR_ADDR_PEAK_LEFT) begin
            next_rdata = {2'b00, adc_peak_left};
        end else if (i_addr == ACR_ADDR_PEAK_RIGHT) begin
            next_rdata = {2'b00, adc_peak_right};
        end else if (i_addr == ACR_ADDR_PLL_CTRL1) begin
            next_rdata = pll_control_one;
        end else if (i_addr == ACR_ADDR_PLL_CTRL2) begin
            next_rdata = pll_control_two;
        end else begin
            next_rdata = 8'h00;
        end
    end

    // Writable registers. Reserved bits of control two are masked so they read zero.
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            adc_control_one <= ACR_RESET_BYTE;
            adc_control_two <= ACR_RESET_BYTE;
            adc_left_volume <= ACR_RESET_VOLUME;
            adc_right_volume <= ACR_RESET_VOLUME;
            pll_control_one <= ACR_RESET_BYTE;
            pll_control_two <= ACR_RESET_BYTE;
        end else begin
            if (wr_ctrl1) adc_control_one <= i_wdata;
            if (wr_ctrl2) adc_control_two <= i_wdata & ACR_CTRL2_MASK;
            if (wr_vol_l) adc_left_volume <= i_wdata;
            if (wr_vol_r) adc_right_volume <= i_wdata;
            if (wr_pll1) pll_control_one <= i_wdata;
            if (wr_pll2) pll_control_two <= i_wdata;
        end
    end

    // Peak levels follow the detectors only; the port has no write path here.
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            adc_peak_left <= ACR_PEAK_FLOOR;
            adc_peak_right <= ACR_PEAK_FLOOR;
        end else begin
            adc_peak_left <= i_peak_left;
            adc_peak_right <= i_peak_right;
        end
    end

    // Read data is returned one cycle after the strobe and held until the next read.
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
        end else begin
            o_rdata <= i_read ? next_rdata : o_rdata;
            o_rvalid <= i_read;
        end
    end

    // Decoded ADC clocking.
    wire logic [1:0] mdiv_code = adc_control_two[ACR_B_MDIV_HI:ACR_B_MDIV_LO];
    wire logic [2:0] next_mdiv = (mdiv_code == ACR_CODE_01) ? ACR_DIV_TWO :
                                 (mdiv_code == ACR_CODE_10) ? ACR_DIV_THREE : ACR_DIV_ONE;
    wire logic mod_rate = adc_control_one[ACR_B_MOD_RATE];
    wire logic [2:0] next_mod_div = mod_rate ? ACR_DIV_FOUR : ACR_DIV_TWO;
    wire logic [9:0] next_mod_ratio = mod_rate ? ACR_RATIO_64 : ACR_RATIO_128;

    // Decoded PLL clocking. Reserved source codes are flagged, not guessed at.
    wire logic [1:0] src_code = pll_control_one[ACR_B_SRC_HI:ACR_B_SRC_LO];
    acr_src_e next_src;
    assign next_src = (src_code == ACR_CODE_00) ? ACR_SRC_PLL :
                      (src_code == ACR_CODE_11) ? ACR_SRC_SPDIF : ACR_SRC_BAD;
    wire logic [9:0] next_sys3_ratio = pll_control_one[ACR_B_SYS3_RATIO] ?
                                       ACR_RATIO_256 : ACR_RATIO_512;
    wire logic [2:0] next_mout_div = pll_control_one[ACR_B_MOUT_HALVE] ?
                                     ACR_DIV_TWO : ACR_DIV_ONE;
    wire logic [2:0] next_xtal_div = pll_control_one[ACR_B_XTAL_HALVE] ?
                                     ACR_DIV_TWO : ACR_DIV_ONE;

    // Controls registered once so every output leaves from a flop.
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_modulator_divide <= ACR_DIV_TWO;
            o_modulator_ratio <= ACR_RATIO_128;
            o_high_pass_enable <= 1'b0;
            o_converter_sleep <= 1'b0;
            o_analog_section_sleep <= 1'b0;
            o_left_gain_amp_sleep <= 1'b0;
            o_right_gain_amp_sleep <= 1'b0;
            o_reference_buffer_sleep <= 1'b0;
            o_adc_master_divide <= ACR_DIV_ONE;
            o_third_clock_source <= ACR_SRC_PLL;
            o_third_clock_ratio <= ACR_RATIO_512;
            o_master_out_divide <= ACR_DIV_ONE;
            o_xtal_divide <= ACR_DIV_ONE;
            o_second_pll_sleep <= 1'b0;
            o_first_pll_sleep <= 1'b0;
            o_oscillator_sleep <= 1'b0;
        end else begin
            o_modulator_divide <= next_mod_div;
            o_modulator_ratio <= next_mod_ratio;
            o_high_pass_enable <= adc_control_one[ACR_B_HPF];
            o_converter_sleep <= adc_control_one[ACR_B_CONV_SLEEP];
            o_analog_section_sleep <= adc_control_one[ACR_B_ANA_SLEEP];
            o_left_gain_amp_sleep <= adc_control_one[ACR_B_PGA_L_SLEEP];
            o_right_gain_amp_sleep <= adc_control_one[ACR_B_PGA_R_SLEEP];
            o_reference_buffer_sleep <= adc_control_two[ACR_B_REF_SLEEP];
            o_adc_master_divide <= next_mdiv;
            o_third_clock_source <= next_src;
            o_third_clock_ratio <= next_sys3_ratio;
            o_master_out_divide <= next_mout_div;
            o_xtal_divide <= next_xtal_div;
            o_second_pll_sleep <= pll_control_one[ACR_B_PLL2_SLEEP];
            o_first_pll_sleep <= pll_control_one[ACR_B_PLL1_SLEEP];
            o_oscillator_sleep <= pll_control_one[ACR_B_OSC_SLEEP];
        end
    end

    // First PLL decode.
    acr_pll_decode u_first_pll (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_rate_select(pll_control_two[ACR_B_PLL1_FS_HI:ACR_B_PLL1_FS_LO]),
        .i_oversample(pll_control_two[ACR_B_PLL1_SEL]),
        .i_rate_double(pll_control_two[ACR_B_PLL1_DOUB]),
        .o_rate(o_first_pll_rate),
        .o_ratio(o_first_pll_ratio),
        .o_reserved(o_first_pll_reserved)
    );

    // Second PLL decode.
    acr_pll_decode u_second_pll (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_rate_select(pll_control_two[ACR_B_PLL2_FS_HI:ACR_B_PLL2_FS_LO]),
        .i_oversample(pll_control_two[ACR_B_PLL2_SEL]),
        .i_rate_double(pll_control_two[ACR_B_PLL2_DOUB]),
        .o_rate(o_second_pll_rate),
        .o_ratio(o_second_pll_ratio),
        .o_reserved(o_second_pll_reserved)
    );

    // Left channel volume and mute.
    acr_channel_gain #(.WIDTH(SAMPLE_WIDTH)) u_gain_left (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_gain(adc_left_volume),
        .i_mute(adc_control_one[ACR_B_MUTE_L]),
        .i_sample(i_sample_left),
        .i_valid(i_sample_valid),
        .o_sample(o_sample_left),
        .o_valid(o_sample_valid)
    );

    // Right channel; its valid matches the left one and is left unread.
    acr_channel_gain #(.WIDTH(SAMPLE_WIDTH)) u_gain_right (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_gain(adc_right_volume),
        .i_mute(adc_control_one[ACR_B_MUTE_R]),
        .i_sample(i_sample_right),
        .i_valid(i_sample_valid),
        .o_sample(o_sample_right),
        .o_valid()
    );

    // Checks.
    AST_MOD_RATE: assert property (@(posedge i_clock) disable iff (!i_nrst)
        wr_ctrl1 ##1 !wr_ctrl1 |=> o_modulator_ratio == ($past(i_wdata[ACR_B_MOD_RATE], 2) ?
            ACR_RATIO_64 : ACR_RATIO_128))
        else $error("Modulator ratio does not follow its select bit.");
    AST_MUTE_LEFT: assert property (@(posedge i_clock) disable iff (!i_nrst)
        adc_control_one[ACR_B_MUTE_L] && i_sample_valid |=> o_sample_left == '0)
        else $error("Muted left channel passed a sample.");
    // The edge right after reset sees the pre-reset register in $past, so it is skipped.
    AST_ANA_SLEEP: assert property (@(posedge i_clock) disable iff (!i_nrst)
        $past(i_nrst) |-> o_analog_section_sleep == $past(adc_control_one[ACR_B_ANA_SLEEP]))
        else $error("Analog sleep does not follow its bit.");
    AST_REF_SLEEP: assert property (@(posedge i_clock) disable iff (!i_nrst)
        wr_ctrl2 |=> ##1 o_reference_buffer_sleep == $past(i_wdata[ACR_B_REF_SLEEP], 2))
        else $error("Reference buffer sleep does not follow its bit.");
    AST_MDIV: assert property (@(posedge i_clock) disable iff (!i_nrst)
        mdiv_code == ACR_CODE_10 |=> o_adc_master_divide == ACR_DIV_THREE)
        else $error("Master divider code two did not divide by three.");
    AST_PEAK_RO: assert property (@(posedge i_clock) disable iff (!i_nrst)
        $past(i_nrst) |-> adc_peak_left == $past(i_peak_left))
        else $error("Peak level did not track its detector.");
    AST_MUTE_RIGHT: assert property (@(posedge i_clock) disable iff (!i_nrst)
        adc_control_one[ACR_B_MUTE_R] && i_sample_valid |=> o_sample_right == '0)
        else $error("Muted right channel passed a sample.");
    AST_XTAL_DIV: assert property (@(posedge i_clock) disable iff (!i_nrst)
        pll_control_one[ACR_B_XTAL_HALVE] |=> o_xtal_divide == ACR_DIV_TWO)
        else $error("Crystal halve bit did not divide the reference by two.");
    AST_SRC: assert property (@(posedge i_clock) disable iff (!i_nrst)
        src_code == ACR_CODE_11 |=> o_third_clock_source == ACR_SRC_SPDIF)
        else $error("Third clock source not taken from the receiver.");
    AST_PLL1_RATE: assert property (@(posedge i_clock) disable iff (!i_nrst)
        pll_control_two[ACR_B_PLL1_FS_HI:ACR_B_PLL1_FS_LO] == ACR_CODE_00 &&
        pll_control_two[ACR_B_PLL1_DOUB] |=> o_first_pll_rate == {ACR_FS_48K, 1'b0})
        else $error("First PLL doubled rate is wrong.");
endmodule // acr_regs
`default_nettype wire

// [design/acr_pkg.sv]
/*
 * Package for the ADC and PLL control register bank: register addresses,
 * field positions, reset values and decoded rate and ratio constants.
 * Assumes a 7-bit register address and 8-bit data from the control port.
 */
package acr_pkg;
    // Register addresses on the serial control port.
    localparam logic [6:0] ACR_ADDR_ADC_CTRL1 = 7'h6e;
    localparam logic [6:0] ACR_ADDR_ADC_CTRL2 = 7'h6f;
    localparam logic [6:0] ACR_ADDR_VOL_LEFT = 7'h70;
    localparam logic [6:0] ACR_ADDR_VOL_RIGHT = 7'h71;
    localparam logic [6:0] ACR_ADDR_PEAK_LEFT = 7'h72;
    localparam logic [6:0] ACR_ADDR_PEAK_RIGHT = 7'h73;
    localparam logic [6:0] ACR_ADDR_PLL_CTRL1 = 7'h74;
    localparam logic [6:0] ACR_ADDR_PLL_CTRL2 = 7'h75;

    // Reset values of the writable registers and the peak levels.
    localparam logic [7:0] ACR_RESET_BYTE = 8'h00;
    localparam logic [7:0] ACR_RESET_VOLUME = 8'h00;
    localparam logic [5:0] ACR_PEAK_FLOOR = 6'h3f;

    // Writable-bit mask of control register 2, whose reserved bits read as zero, and the six-bit peak mask.
    localparam logic [7:0] ACR_CTRL2_MASK = 8'h13;
    localparam logic [7:0] ACR_PEAK_MASK = 8'h3f;

    // Field positions, control register 1.
    localparam int ACR_B_MOD_RATE = 7;
    localparam int ACR_B_HPF = 6;
    localparam int ACR_B_CONV_SLEEP = 5;
    localparam int ACR_B_ANA_SLEEP = 4;
    localparam int ACR_B_MUTE_R = 3;
    localparam int ACR_B_MUTE_L = 2;
    localparam int ACR_B_PGA_L_SLEEP = 1;
    localparam int ACR_B_PGA_R_SLEEP = 0;
    // Control register 2.
    localparam int ACR_B_REF_SLEEP = 4;
    localparam int ACR_B_MDIV_HI = 1;
    localparam int ACR_B_MDIV_LO = 0;
    // PLL control register 1.
    localparam int ACR_B_SRC_HI = 7;
    localparam int ACR_B_SRC_LO = 6;
    localparam int ACR_B_MOUT_HALVE = 5;
    localparam int ACR_B_XTAL_HALVE = 4;
    localparam int ACR_B_PLL2_SLEEP = 3;
    localparam int ACR_B_PLL1_SLEEP = 2;
    localparam int ACR_B_OSC_SLEEP = 1;
    localparam int ACR_B_SYS3_RATIO = 0;
    // PLL control register 2.
    localparam int ACR_B_PLL2_FS_HI = 7;
    localparam int ACR_B_PLL2_FS_LO = 6;
    localparam int ACR_B_PLL2_SEL = 5;
    localparam int ACR_B_PLL2_DOUB = 4;
    localparam int ACR_B_PLL1_FS_HI = 3;
    localparam int ACR_B_PLL1_FS_LO = 2;
    localparam int ACR_B_PLL1_SEL = 1;
    localparam int ACR_B_PLL1_DOUB = 0;

    // Decoded figures.
    localparam logic [2:0] ACR_DIV_ONE = 3'h1;
    localparam logic [2:0] ACR_DIV_TWO = 3'h2;
    localparam logic [2:0] ACR_DIV_THREE = 3'h3;
    localparam logic [2:0] ACR_DIV_FOUR = 3'h4;
    localparam logic [9:0] ACR_RATIO_64 = 10'h040;
    localparam logic [9:0] ACR_RATIO_128 = 10'h080;
    localparam logic [9:0] ACR_RATIO_256 = 10'h100;
    localparam logic [9:0] ACR_RATIO_384 = 10'h180;
    localparam logic [9:0] ACR_RATIO_512 = 10'h200;
    // Sample rates in units of 100 Hz.
    localparam logic [10:0] ACR_FS_48K = 11'h1e0;
    localparam logic [10:0] ACR_FS_32K = 11'h140;
    localparam logic [10:0] ACR_FS_44K1 = 11'h1b9;
    localparam logic [10:0] ACR_FS_NONE = 11'h000;
    localparam logic [1:0] ACR_CODE_00 = 2'h0;
    localparam logic [1:0] ACR_CODE_01 = 2'h1;
    localparam logic [1:0] ACR_CODE_10 = 2'h2;
    localparam logic [1:0] ACR_CODE_11 = 2'h3;

    // Source of the third system clock.
    typedef enum logic [2:0] {
        ACR_SRC_PLL = 3'b001,
        ACR_SRC_SPDIF = 3'b010,
        ACR_SRC_BAD = 3'b100
    } acr_src_e;
endpackage

// [design/acr_pll_decode.sv]
/*
 * Decodes one PLL's rate select, oversample and doubling bits into a
 * sample rate and an output ratio. Purely registered, one cycle of delay.
 * Assumes the fields come straight from the register flops.
 */
`timescale 1ns/100ps
`default_nettype none
module acr_pll_decode
    import acr_pkg::*;
(
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_nrst,
    // Fields.
    input wire logic [1:0] i_rate_select,
    input wire logic i_oversample,
    input wire logic i_rate_double,
    // Decoded.
    output logic [11:0] o_rate,
    output logic [9:0] o_ratio,
    output logic o_reserved
);
    import acr_pkg::*;

    // Base rate table; code 01 is reserved and gives no rate.
    wire logic [10:0] base_rate = (i_rate_select == ACR_CODE_00) ? ACR_FS_48K :
                                  (i_rate_select == ACR_CODE_10) ? ACR_FS_32K :
                                  (i_rate_select == ACR_CODE_11) ? ACR_FS_44K1 : ACR_FS_NONE;
    // Doubling shifts the base up one place, so the result is one bit wider.
    wire logic [11:0] next_rate = i_rate_double ? {base_rate, 1'b0} : {1'b0, base_rate};
    wire logic [9:0] next_ratio = i_oversample ? ACR_RATIO_384 : ACR_RATIO_256;

    // Outputs are registered so the top sees flop-driven values.
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_rate <= 12'h000;
            o_ratio <= ACR_RATIO_256;
            o_reserved <= 1'b0;
        end else begin
            o_rate <= next_rate;
            o_ratio <= next_ratio;
            o_reserved <= (i_rate_select == ACR_CODE_01);
        end
    end
endmodule // acr_pll_decode
`default_nettype wire

// [design/acr_channel_gain.sv]
/*
 * One ADC channel's linear volume and mute stage. Product is taken as
 * sample times (code+1)/256, so 0xff is unity, 0x7f is one half and 0x00
 * is 1/256. Assumes signed samples arriving with a one-cycle valid.
 */
`timescale 1ns/100ps
`default_nettype none
module acr_channel_gain #(
    parameter int WIDTH = 24
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_nrst,
    // Control.
    input wire logic [7:0] i_gain,
    input wire logic i_mute,
    // Samples.
    input wire logic signed [WIDTH-1:0] i_sample,
    input wire logic i_valid,
    output logic signed [WIDTH-1:0] o_sample,
    output logic o_valid
);
    // Gain code plus one, as an unsigned 9-bit multiplier.
    wire logic signed [9:0] mult = signed'({1'b0, ({1'b0, i_gain} + 9'h001)});
    wire logic signed [WIDTH+9:0] product = i_sample * mult;
    // Drop eight fraction bits; a muted channel yields silence.
    wire logic signed [WIDTH-1:0] next_sample = i_mute ? '0 : product[WIDTH+7:8];

    // The arithmetic shift keeps the sign; truncation rounds toward minus infinity.
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_sample <= '0;
            o_valid <= 1'b0;
        end else begin
            o_sample <= i_valid ? next_sample : o_sample;
            o_valid <= i_valid;
        end
    end
endmodule // acr_channel_gain
`default_nettype wire

// [sim/tb_adc_pll_control_regs.sv]
/*
 * Self-checking bench for the ADC and PLL control register bank.
 * Assumes acr_pkg and acr_regs are compiled first; the bench drives every port.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_adc_pll_control_regs;
    import acr_pkg::*;
    logic i_clock, i_nrst, i_write, i_read, i_sample_valid, o_rvalid, o_sample_valid;
    logic [6:0] i_addr;
    logic [7:0] i_wdata, o_rdata;
    logic [5:0] i_peak_left, i_peak_right;
    logic signed [23:0] i_sample_left, i_sample_right, o_sample_left, o_sample_right;
    logic o_high_pass_enable, o_converter_sleep, o_analog_section_sleep, o_left_gain_amp_sleep;
    logic o_right_gain_amp_sleep, o_reference_buffer_sleep, o_second_pll_sleep;
    logic o_first_pll_sleep, o_oscillator_sleep, o_first_pll_reserved, o_second_pll_reserved;
    logic [2:0] o_modulator_divide, o_adc_master_divide, o_master_out_divide, o_xtal_divide;
    logic [9:0] o_modulator_ratio, o_third_clock_ratio, o_first_pll_ratio, o_second_pll_ratio;
    logic [11:0] o_first_pll_rate, o_second_pll_rate;
    acr_src_e o_third_clock_source;
    logic [7:0] m[8];
    logic [7:0] d[8];
    int fail_count = 0;
    int num_checks = 0;
    int seed = 32'h5872;

    acr_regs acr_regs_i (.*);

    // Free-running bench clock, 8 ns period.
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    task automatic complete_run();
        if (fail_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for a strobe; a missing answer ends the run.
    task automatic wait_flag(input int s);
        for (int n = 0; n < 4; n++) begin
            if ((s != 0 ? o_sample_valid : o_rvalid) === 1'b1) return;
            @(posedge i_clock) #1;
        end
        fail_count++;
        $display("mismatch at %0t: no answer", $time);
        complete_run();
    endtask

    // The strobe is left high so that writes can run back to back.
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        i_write = 1'b1;
        i_addr = a;
        i_wdata = v;
        @(posedge i_clock) #1;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        i_write = 1'b0;
        i_read = 1'b1;
        i_addr = a;
        @(posedge i_clock) #1;
        i_read = 1'b0;
        wait_flag(0);
        chk(o_rdata, e);
        @(posedge i_clock) #1;
    endtask

    // Model of one PLL: rate in 100 Hz units, ratio and reserved flag.
    function automatic logic [22:0] pll(input logic [3:0] f);
        logic [11:0] r;
        r = f[3:2] == 2'h0 ? 12'h1e0 : f[3:2] == 2'h2 ? 12'h140 : f[3:2] == 2'h3 ? 12'h1b9 : 12'h0;
        if (f[0]) r = r << 1;
        return {r, f[1] ? 10'h180 : 10'h100, f[3:2] == 2'h1};
    endfunction

    function automatic logic [23:0] scale(input logic signed [23:0] s, input logic [7:0] g,
                                          input logic mu);
        longint p;
        p = longint'(s) * (int'(g) + 1);
        return mu ? 24'h0 : 24'(p >>> 8);
    endfunction

    task automatic chk_ctrl();
        chk(o_modulator_divide, m[0][7] ? 4 : 2);
        chk(o_modulator_ratio, m[0][7] ? 64 : 128);
        chk({o_high_pass_enable, o_converter_sleep, o_left_gain_amp_sleep, o_right_gain_amp_sleep},
            {m[0][6:5], m[0][1:0]});
        chk(o_analog_section_sleep, m[0][4]);
        chk(o_reference_buffer_sleep, m[1][4]);
        chk(o_adc_master_divide, m[1][1:0] == 1 ? 2 : m[1][1:0] == 2 ? 3 : 1);
        chk(o_third_clock_source, m[6][7:6] == 0 ? 1 : m[6][7:6] == 3 ? 2 : 4);
        chk(o_master_out_divide, m[6][5] ? 2 : 1);
        chk(o_xtal_divide, m[6][4] ? 2 : 1);
        chk({o_second_pll_sleep, o_first_pll_sleep, o_oscillator_sleep}, m[6][3:1]);
        chk(o_third_clock_ratio, m[6][0] ? 256 : 512);
        chk({o_second_pll_rate, o_second_pll_ratio, o_second_pll_reserved},
            pll(m[7][7:4]));
        chk({o_first_pll_rate, o_first_pll_ratio, o_first_pll_reserved},
            pll(m[7][3:0]));
    endtask

    // Reset, then every non-reserved rate code pair with random fields, samples and peaks.
    initial begin
        {i_nrst, i_write, i_read, i_sample_valid, i_addr, i_wdata} = '0;
        {i_peak_left, i_peak_right, i_sample_left, i_sample_right} = '0;
        m = '{default: 8'h00};
        repeat (16) @(posedge i_clock);
        #1 i_nrst = 1'b1;
        for (int i = 0; i < 17; i++) begin
            if (i == 16) begin
                // A second reset in mid-run must bring every control back.
                i_nrst = 1'b0;
                @(posedge i_clock) #1;
                i_nrst = 1'b1;
                m = '{default: 8'h00};
            end else begin
                for (int k = 0; k < 8; k++) d[k] = 8'($random(seed));
                {i_peak_left, i_peak_right} = 12'($random(seed));
                // Software keeps reserved bits clear and never writes a reserved code.
                d[1] = d[1] & ACR_CTRL2_MASK;
                d[6][7:6] = {2{i[0]}};
                d[7][7:6] = (2'(i >> 2) == 2'h1) ? 2'h3 : 2'(i >> 2);
                d[7][3:2] = (2'(i) == 2'h1) ? 2'h3 : 2'(i);
                for (int k = 0; k < 8; k++) wr(7'(7'h6e + k), d[k]);
                wr(7'h10, d[0]);
                m = d;
                m[1] = d[1] & ACR_CTRL2_MASK;
            end
            m[4] = {2'h0, i_peak_left};
            m[5] = {2'h0, i_peak_right};
            i_write = 1'b0;
            repeat (3) @(posedge i_clock) #1;
            chk_ctrl();
            for (int k = 0; k < 8; k++) rd(7'(7'h6e + k), m[k]);
            rd(7'h10, 8'h00);
            {i_sample_left, i_sample_right} = 48'({$random(seed), $random(seed)});
            i_sample_valid = 1'b1;
            @(posedge i_clock) #1;
            i_sample_valid = 1'b0;
            wait_flag(1);
            chk(o_sample_left[23:0], scale(i_sample_left, m[2], m[0][2]));
            chk(o_sample_right[23:0], scale(i_sample_right, m[3], m[0][3]));
            @(posedge i_clock) #1;
        end
        complete_run();
    end
endmodule // tb_adc_pll_control_regs
`default_nettype wire
